// ---- shared/utevr_pkg.sv ----
// Package: register map, field layout and carrier types of the serial port event block
package utevr_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_START_RX   = 12'h000;
    localparam logic [11:0] OFF_STOP_RX    = 12'h004;
    localparam logic [11:0] OFF_START_TX   = 12'h008;
    localparam logic [11:0] OFF_STOP_TX    = 12'h00c;
    localparam logic [11:0] OFF_SUSPEND    = 12'h01c;
    localparam logic [11:0] OFF_EV_CTS     = 12'h100;
    localparam logic [11:0] OFF_EV_NCTS    = 12'h104;
    localparam logic [11:0] OFF_EV_RXRDY   = 12'h108;
    localparam logic [11:0] OFF_EV_TXRDY   = 12'h11c;
    localparam logic [11:0] OFF_EV_ERROR   = 12'h124;
    localparam logic [11:0] OFF_EV_RXTO    = 12'h144;
    localparam logic [11:0] OFF_LINKS      = 12'h200;
    localparam logic [11:0] OFF_IRQ_SET    = 12'h304;
    localparam logic [11:0] OFF_IRQ_CLR    = 12'h308;

    // Event bit positions, shared by irq enable layout
    localparam int EV_CTS    = 0;
    localparam int EV_NCTS   = 1;
    localparam int EV_RXRDY  = 2;
    localparam int EV_TXRDY  = 3;
    localparam int EV_ERROR  = 4;
    localparam int EV_RXTO   = 5;
    localparam int NUM_EV    = 6;

    // Link bit positions
    localparam int LNK_FLOW_ON_START = 0;
    localparam int LNK_FLOW_OFF_STOP = 1;

    // Reset values
    localparam logic [NUM_EV-1:0] EVENTS_RST = 6'h00;
    localparam logic [1:0]        LINKS_RST  = 2'h0;
    localparam logic [NUM_EV-1:0] IRQEN_RST  = 6'h00;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Task strobes toward the serial engine
    typedef struct packed {
        logic receive_start_task;
        logic receive_stop_task;
        logic tx_start_task;
        logic tx_stop_trigger;
        logic suspend_trigger;
    } utevr_tasks_t;

    // Event pulses from the serial engine
    typedef struct packed {
        logic rx_ready;
        logic tx_ready;
        logic line_error;
        logic rx_timeout;
    } utevr_engine_ev_t;

endpackage

// ---- hdl/utevr_cts_sync.sv ----
// Clear-to-send pin synchroniser and edge detector
`timescale 1ns/100ps
`default_nettype none

module utevr_cts_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic ce,
    input  wire logic cts_n_pin,
    output logic      fell,
    output logic      rose
);

    // Pin state held in one struct; idle line is high (not clear)
    typedef struct packed {
        logic meta;
        logic sync;
        logic last;
    } utevr_cts_state_t;

    utevr_cts_state_t s_q;
    utevr_cts_state_t s_d;

    // Next state; only sync feeds the comparison, never meta
    always_comb begin
        s_d      = s_q;
        s_d.meta = cts_n_pin;
        s_d.sync = s_q.meta;
        s_d.last = s_q.sync;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= 3'h7;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // One-cycle edge pulses, gated so a frozen block sees none
    assign fell = ce & s_q.last & ~s_q.sync;
    assign rose = ce & ~s_q.last & s_q.sync;

endmodule

`default_nettype wire

// ---- hdl/utevr_regs.sv ----
// Serial port task, event, shortcut and interrupt register block with AXI4-Lite slave
// Summary of operation
// - Clear-to-send pin falling low sets the flow-on event register to one.
// - Clear-to-send pin rising high sets the flow-off event register to one.
// - Received character sets rx ready event; character shifted out sets tx ready.
// - Shortcut register links events to tasks; zero disables, all disabled at reset.
// - Enabled link starts reception automatically on the flow-on event.
// - Enabled link stops reception automatically on the flow-off event.
// - Writing one to irq enable set enables that event; zero leaves it; reads state.
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none

module utevr_regs (
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      ce,
    // AXI4-Lite slave
    input  wire logic [11:0]               s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [11:0]               s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready,
    // Line and serial engine
    input  wire logic                      cts_n_pin,
    input  wire utevr_pkg::utevr_engine_ev_t engine_ev,
    output utevr_pkg::utevr_tasks_t        tasks,
    output logic                           irq
);

    localparam int NE = utevr_pkg::NUM_EV;

    // Whole register state of the block
    typedef struct packed {
        logic [NE-1:0]  events;
        logic [1:0]     links;
        logic [NE-1:0]  irq_en;
        logic           aw_full;
        logic [11:0]    aw_addr;
        logic           w_full;
        logic [31:0]    w_data;
        logic [3:0]     w_strb;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     rresp;
        utevr_pkg::utevr_tasks_t tasks;
        logic           irq;
    } utevr_state_t;

    utevr_state_t s_q;
    utevr_state_t s_d;

    logic cts_fell;
    logic cts_rose;

    // Pin passes two flops before the edge detect
    utevr_cts_sync u_cts (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ce        (ce),
        .cts_n_pin (cts_n_pin),
        .fell      (cts_fell),
        .rose      (cts_rose)
    );

    // Map an offset to its event bit, or none
    function automatic logic [NE-1:0] ev_sel(input logic [11:0] a);
        logic [NE-1:0] r;
        r = '0;
        unique case (a)
            utevr_pkg::OFF_EV_CTS:   r[utevr_pkg::EV_CTS]   = 1'b1;
            utevr_pkg::OFF_EV_NCTS:  r[utevr_pkg::EV_NCTS]  = 1'b1;
            utevr_pkg::OFF_EV_RXRDY: r[utevr_pkg::EV_RXRDY] = 1'b1;
            utevr_pkg::OFF_EV_TXRDY: r[utevr_pkg::EV_TXRDY] = 1'b1;
            utevr_pkg::OFF_EV_ERROR: r[utevr_pkg::EV_ERROR] = 1'b1;
            utevr_pkg::OFF_EV_RXTO:  r[utevr_pkg::EV_RXTO]  = 1'b1;
            default:                 r = '0;
        endcase
        return r;
    endfunction

    // Whether an offset is a mapped register at all
    function automatic logic is_mapped(input logic [11:0] a);
        logic m;
        m = (ev_sel(a) != '0);
        unique case (a)
            utevr_pkg::OFF_START_RX, utevr_pkg::OFF_STOP_RX, utevr_pkg::OFF_START_TX,
            utevr_pkg::OFF_STOP_TX, utevr_pkg::OFF_SUSPEND, utevr_pkg::OFF_LINKS,
            utevr_pkg::OFF_IRQ_SET, utevr_pkg::OFF_IRQ_CLR: m = 1'b1;
            default: m = m;
        endcase
        return m;
    endfunction

    logic           wr_go;
    logic           rd_go;
    logic [NE-1:0]  hw_set;
    logic [NE-1:0]  wsel;
    logic           wbit;
    logic [NE-1:0]  ev_after;
    logic [NE-1:0]  rsel;
    logic [31:0]    rd_val;

    // Handshake readies: one write and one read in flight
    assign s_axi_awready = ce & ~s_q.aw_full & ~s_q.bvalid;
    assign s_axi_wready  = ce & ~s_q.w_full & ~s_q.bvalid;
    assign s_axi_arready = ce & ~s_q.rvalid;

    // Register outputs
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp  = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata  = s_q.rdata;
    assign s_axi_rresp  = s_q.rresp;
    assign tasks        = s_q.tasks;
    assign irq          = s_q.irq;

    // Hardware event sources
    always_comb begin
        hw_set                        = '0;
        hw_set[utevr_pkg::EV_CTS]     = cts_fell;
        hw_set[utevr_pkg::EV_NCTS]    = cts_rose;
        hw_set[utevr_pkg::EV_RXRDY]   = engine_ev.rx_ready;
        hw_set[utevr_pkg::EV_TXRDY]   = engine_ev.tx_ready;
        hw_set[utevr_pkg::EV_ERROR]   = engine_ev.line_error;
        hw_set[utevr_pkg::EV_RXTO]    = engine_ev.rx_timeout;
    end

    // Read mux; write-only triggers read as zero
    always_comb begin
        rsel   = ev_sel(s_axi_araddr);
        rd_val = 32'h0000_0000;
        if (rsel != '0) begin
            rd_val[0] = |(s_q.events & rsel);
        end else if (s_axi_araddr == utevr_pkg::OFF_LINKS) begin
            rd_val[1:0] = s_q.links;
        end else if (s_axi_araddr == utevr_pkg::OFF_IRQ_SET || s_axi_araddr == utevr_pkg::OFF_IRQ_CLR) begin
            rd_val[NE-1:0] = s_q.irq_en;
        end
    end

    // Next-state logic for bus, registers and task strobes
    always_comb begin
        s_d = s_q;
        s_d.tasks = '0;

        // Capture address and data independently, either order
        if (s_axi_awvalid && s_axi_awready) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            s_d.w_full = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end

        wr_go = s_q.aw_full & s_q.w_full;
        wsel  = ev_sel(s_q.aw_addr);
        wbit  = s_q.w_data[0] & s_q.w_strb[0];
        ev_after = s_q.events;

        // Software write; byte lane 0 carries every field here
        if (wr_go) begin
            s_d.aw_full = 1'b0;
            s_d.w_full  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = is_mapped(s_q.aw_addr) ? utevr_pkg::RESP_OKAY : utevr_pkg::RESP_SLVERR;
            if (s_q.w_strb[0]) begin
                // Writing zero clears an event; writing one also stores it
                for (int i = 0; i < NE; i++) begin
                    if (wsel[i]) begin
                        ev_after[i] = wbit;
                    end
                end
                unique case (s_q.aw_addr)
                    utevr_pkg::OFF_START_RX: s_d.tasks.receive_start_task = s_q.w_data[0];
                    utevr_pkg::OFF_STOP_RX:  s_d.tasks.receive_stop_task  = s_q.w_data[0];
                    utevr_pkg::OFF_START_TX: s_d.tasks.tx_start_task      = s_q.w_data[0];
                    utevr_pkg::OFF_STOP_TX:  s_d.tasks.tx_stop_trigger    = s_q.w_data[0];
                    utevr_pkg::OFF_SUSPEND:  s_d.tasks.suspend_trigger    = s_q.w_data[0];
                    utevr_pkg::OFF_LINKS:    s_d.links = s_q.w_data[1:0];
                    utevr_pkg::OFF_IRQ_SET:  s_d.irq_en = s_q.irq_en | s_q.w_data[NE-1:0];
                    utevr_pkg::OFF_IRQ_CLR:  s_d.irq_en = s_q.irq_en & ~s_q.w_data[NE-1:0];
                    default: ;
                endcase
            end
        end

        // Hardware set wins over a software clear in the same cycle
        s_d.events = ev_after | hw_set;

        // Shortcuts fire tasks on the event pulse itself, no software in the loop
        if (s_q.links[utevr_pkg::LNK_FLOW_ON_START] && cts_fell) begin
            s_d.tasks.receive_start_task = 1'b1;
        end
        if (s_q.links[utevr_pkg::LNK_FLOW_OFF_STOP] && cts_rose) begin
            s_d.tasks.receive_stop_task = 1'b1;
        end

        // Write response
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // Read: answer one cycle after the address is taken
        rd_go = s_axi_arvalid & s_axi_arready;
        if (rd_go) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = rd_val;
            s_d.rresp  = is_mapped(s_axi_araddr) ? utevr_pkg::RESP_OKAY : utevr_pkg::RESP_SLVERR;
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        // Level interrupt from registered events and enables
        s_d.irq = |(s_d.events & s_d.irq_en);
    end

    // Single state register; clock enable freezes everything
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q        <= '0;
            s_q.events <= utevr_pkg::EVENTS_RST;
            s_q.links  <= utevr_pkg::LINKS_RST;
            s_q.irq_en <= utevr_pkg::IRQEN_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

endmodule

`default_nettype wire

// ---- verif/utevr_regs_props.sv ----
// Property checker for the serial port event register block
`timescale 1ns/100ps
`default_nettype none

module utevr_regs_props (
    input wire logic                    aclk,
    input wire logic                    aresetn,
    input wire logic                    s_axi_awready,
    input wire logic [1:0]              s_axi_bresp,
    input wire logic                    s_axi_bvalid,
    input wire logic                    s_axi_bready,
    input wire logic                    s_axi_arvalid,
    input wire logic                    s_axi_arready,
    input wire logic [31:0]             s_axi_rdata,
    input wire logic                    s_axi_rvalid,
    input wire logic                    s_axi_rready,
    input wire logic                    cts_n_pin,
    input wire utevr_pkg::utevr_engine_ev_t engine_ev,
    input wire utevr_pkg::utevr_tasks_t tasks,
    input wire logic                    irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Answers stand until the master takes them
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken while response pending");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    // Shortcut strobes need a settled line level behind them
    start_cause_a: assert property (tasks.receive_start_task && !$rose(s_axi_bvalid) |-> !$past(cts_n_pin, 2))
        else $error("receive start without flow on");
    stop_cause_a: assert property (tasks.receive_stop_task && !$rose(s_axi_bvalid) |-> $past(cts_n_pin, 2))
        else $error("receive stop without flow off");
    // A register write raises irq in the same cycle as its response, so the write cause is the response edge
    irq_src_a: assert property ($rose(irq) |->
        $past(engine_ev) != '0 || $rose(s_axi_bvalid) || $past(cts_n_pin, 3) != $past(cts_n_pin, 6))
        else $error("interrupt without a cause");

    c_irq: cover property ($rose(irq));
    c_start: cover property (tasks.receive_start_task);
    c_stop: cover property (tasks.receive_stop_task);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == utevr_pkg::RESP_SLVERR);
endmodule

bind utevr_regs utevr_regs_props u_props (.aclk, .aresetn, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .cts_n_pin, .engine_ev, .tasks, .irq);

`default_nettype wire

// ---- verif/utevr_peer.sv ----
// Remote serial peer: drives the clear-to-send line after a set delay
`timescale 1ns/100ps
`default_nettype none

module utevr_peer #(
    parameter int DLY = 3
) (
    input  wire logic aclk,
    input  wire logic allow,
    output logic      cts_n_pin
);
    logic [DLY-1:0] pipe_q = '1;

    // Slow answer; line idles high, so no flow-on at start
    always_ff @(posedge aclk) pipe_q <= {pipe_q[DLY-2:0], ~allow};
    assign cts_n_pin = pipe_q[DLY-1];
endmodule

`default_nettype wire

// ---- verif/utevr_regs_bench.sv ----
// Self-checking bench for the serial port event register block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, e, s); end end

module utevr_regs_bench;
    logic aclk = 0, aresetn = 0, ce = 1, allow = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, cts_n_pin;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    utevr_pkg::utevr_engine_ev_t engine_ev = '0;
    utevr_pkg::utevr_tasks_t tasks;
    int n_mismatch = 0, tests_run = 0;
    int pc[5] = '{default: 0};
    logic [11:0] offs[6] = '{12'h100, 12'h104, 12'h108, 12'h11c, 12'h124, 12'h144};

    utevr_regs u_dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .cts_n_pin, .engine_ev, .tasks, .irq);
    utevr_peer #(.DLY(3)) u_peer (.aclk, .allow, .cts_n_pin);

    initial begin
        forever #25 aclk = ~aclk;
    end

    // Count task strobes, one per high cycle
    always @(posedge aclk)
        for (int i = 0; i < 5; i++)
            if (tasks[i] === 1'b1) pc[i]++;

    task automatic print_verdict();
        if (n_mismatch == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Write: both channels offered together, each dropped once taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 0;
        if (n >= 50) begin
            n_mismatch++;
            print_verdict();
        end
        `CHK("bresp", er, s_axi_bresp)
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 0;
        if (n >= 50) begin
            n_mismatch++;
            print_verdict();
        end
        `CHK("rdata", e, s_axi_rdata)
        `CHK("rresp", er, s_axi_rresp)
    endtask

    // One-cycle engine pulse, msb first: rx, tx, error, timeout
    task automatic pulse(input logic [3:0] b);
        @(posedge aclk);
        engine_ev <= b;
        @(posedge aclk);
        engine_ev <= '0;
    endtask

    // Peer delay plus two-stage sync leaves margin in 12 cycles
    task automatic flow(input logic v);
        @(posedge aclk);
        allow <= v;
        repeat (12) @(posedge aclk);
    endtask

    task automatic t_reset();
        for (int i = 0; i < 6; i++)
            rd(offs[i], 32'h0, 2'h0);
        rd(12'h200, 32'h0, 2'h0);
        rd(12'h304, 32'h0, 2'h0);
        `CHK("irq", 1'b0, irq)
    endtask

    task automatic t_engine();
        for (int i = 0; i < 4; i++) begin
            pulse(4'h8 >> i);
            rd(offs[i + 2], 32'h1, 2'h0);
            wr(offs[i + 2], 32'h0);
            rd(offs[i + 2], 32'h0, 2'h0);
        end
    endtask

    task automatic t_irq();
        pulse(4'h8);
        `CHK("irq", 1'b0, irq)
        wr(12'h304, 32'h4);
        @(posedge aclk);
        `CHK("irq", 1'b1, irq)
        wr(12'h304, 32'h0);
        rd(12'h304, 32'h4, 2'h0);
        wr(12'h108, 32'h0);
        @(posedge aclk);
        `CHK("irq", 1'b0, irq)
        rd(12'h0f0, 32'h0, utevr_pkg::RESP_SLVERR);
        wr(12'h0f0, 32'h1, utevr_pkg::RESP_SLVERR);
        wr(12'h01c, 32'h1);
        // Strobe counter runs at the same edge as the response; let it settle
        @(posedge aclk);
        `CHK("suspend", 1, pc[0])
        rd(12'h01c, 32'h0, 2'h0);
        wr(12'h308, 32'h4);
        rd(12'h304, 32'h0, 2'h0);
    endtask

    // Software task writes pulse their strobe once each
    task automatic t_tasks();
        wr(12'h000, 32'h1);
        wr(12'h004, 32'h1);
        wr(12'h008, 32'h1);
        wr(12'h00c, 32'h1);
        @(posedge aclk);
        `CHK("start", 2, pc[4])
        `CHK("stop", 2, pc[3])
        `CHK("tx start", 1, pc[2])
        `CHK("tx stop", 1, pc[1])
    endtask

    // Frozen clock enable drops events; mid-run reset clears links and enables
    task automatic t_rerst();
        @(posedge aclk);
        ce <= 0;
        @(posedge aclk);
        `CHK("awready", 1'b0, s_axi_awready)
        pulse(4'h4);
        @(posedge aclk);
        ce <= 1;
        rd(12'h11c, 32'h0, 2'h0);
        wr(12'h200, 32'h3);
        wr(12'h304, 32'h3f);
        pulse(4'h8);
        @(posedge aclk);
        `CHK("irq", 1'b1, irq)
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        `CHK("irq", 1'b0, irq)
        rd(12'h200, 32'h0, 2'h0);
        rd(12'h304, 32'h0, 2'h0);
        rd(12'h108, 32'h0, 2'h0);
    endtask

    // Each link honoured alone, the other left idle
    task automatic t_flow();
        wr(12'h200, 32'h1);
        flow(1);
        rd(12'h100, 32'h1, 2'h0);
        `CHK("start", 1, pc[4])
        flow(0);
        rd(12'h104, 32'h1, 2'h0);
        `CHK("stop", 0, pc[3])
        wr(12'h200, 32'h2);
        rd(12'h200, 32'h2, 2'h0);
        flow(1);
        `CHK("start", 1, pc[4])
        flow(0);
        `CHK("stop", 1, pc[3])
    endtask

    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        t_reset();
        t_engine();
        t_irq();
        t_flow();
        t_tasks();
        t_rerst();
        print_verdict();
    end
endmodule

`default_nettype wire
